// File: rtl/video_blank_pkg.sv
package video_blank_pkg;

    // ------------------------------------------------------------------
    // Data words and pipeline sizes.
    // ------------------------------------------------------------------
    localparam int CHAN_W      = 10;
    localparam int PIX_W       = 2 * CHAN_W;
    localparam int FIFO_DEPTH  = 16;
    localparam int FIFO_AW     = 4;
    localparam int LEVEL_W     = FIFO_AW + 1;
    // Room kept free for the word in flight and the one accepted this cycle.
    localparam logic [LEVEL_W-1:0] FILL_LIMIT = 5'h0c;

    typedef struct packed {
        logic [CHAN_W-1:0] luma;
        logic [CHAN_W-1:0] chroma;
    } pix_word_t;

    typedef struct packed {
        logic blank_n;
        logic field;
    } pix_ctrl_t;

    // ------------------------------------------------------------------
    // Video code values and timing code bit positions.
    // ------------------------------------------------------------------
    localparam logic [CHAN_W-1:0] BLANK_LUMA   = 10'h040;
    localparam logic [CHAN_W-1:0] BLANK_CHROMA = 10'h200;
    localparam logic [CHAN_W-1:0] CODE_ONES    = 10'h3ff;
    localparam logic [CHAN_W-1:0] CODE_ZEROS   = 10'h000;
    localparam int F_BIT  = 8;
    localparam int V_BIT  = 7;
    localparam int H_BIT  = 6;
    localparam int P3_BIT = 5;
    localparam int P2_BIT = 4;
    localparam int P1_BIT = 3;
    localparam int P0_BIT = 2;

    typedef enum logic [1:0] {
        TRS_IDLE  = 2'b00,
        TRS_ONES  = 2'b01,
        TRS_ZERO1 = 2'b10,
        TRS_ZERO2 = 2'b11
    } trs_t;

    // ------------------------------------------------------------------
    // Register map and fields.
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_COUNT  = 4'h8;
    localparam int CTRL_SW_BLANK  = 0;
    localparam logic CTRL_SW_BLANK_RESET = 1'b0;
    localparam int ST_BLANKING    = 0;
    localparam int ST_REWRITE     = 1;
    localparam int ST_AUTODETECT  = 2;
    localparam int ST_IOPROC      = 3;
    localparam int ST_LEVEL_LSB   = 8;
    localparam int COUNT_W        = 16;

endpackage

// File: rtl/sync3.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Three-stage synchroniser for a static control pin.
// ----------------------------------------------------------------------
module sync3 (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic d,
    output logic      q
);

    typedef struct packed {
        logic [2:0] sh;
        logic       q;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // The output moves only once the second and third stages agree.
    always_comb begin
        s_nxt    = s_r;
        s_nxt.sh = {s_r.sh[1:0], d};
        if (s_r.sh[1] == s_r.sh[2]) begin
            s_nxt.q = s_r.sh[2];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.q;

endmodule

// File: rtl/word_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Synchronous FIFO with valid and ready on both sides.
// ----------------------------------------------------------------------
module word_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [AW:0]           level
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 level;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic        push;
    logic        pop;

    // Full and empty come straight from the fill level, so both are exact.
    assign in_ready  = (s_r.level != DEPTH[AW:0]);
    assign out_valid = (s_r.level != '0);
    assign out_data  = s_r.mem[s_r.rp];
    assign level     = s_r.level;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        if (push && !pop) begin
            s_nxt.level = s_r.level + 1'b1;
        end else if (pop && !push) begin
            s_nxt.level = s_r.level - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

endmodule

// File: rtl/video_blank_field.sv
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Input blanking and field flag insertion for the parallel video path.
// ----------------------------------------------------------------------
module video_blank_field (
    input  wire logic                                  clock,
    input  wire logic                                  srst,
    input  wire logic                                  ce,
    input  wire logic                                  in_valid,
    output logic                                       in_ready,
    input  wire video_blank_pkg::pix_word_t            in_word,
    input  wire video_blank_pkg::pix_ctrl_t            in_ctrl,
    input  wire logic                                  timing_code_autodetect,
    input  wire logic                                  io_processing_enable,
    output logic                                       out_valid,
    input  wire logic                                  out_ready,
    output video_blank_pkg::pix_word_t                 out_word,
    input  wire logic [video_blank_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [31:0]                           reg_wdata,
    input  wire logic                                  reg_wr,
    input  wire logic                                  reg_rd,
    output logic [31:0]                                reg_rdata
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed {
        video_blank_pkg::trs_t                        pre_luma;
        video_blank_pkg::trs_t                        pre_chroma;
        logic                                         proc_valid;
        video_blank_pkg::pix_word_t                   proc_word;
        logic                                         in_ready;
        logic                                         out_valid;
        video_blank_pkg::pix_word_t                   out_word;
        logic                                         sw_blank;
        logic                                         blank_active;
        logic [video_blank_pkg::COUNT_W-1:0]          rewrite_cnt;
        logic [31:0]                                  rd_data;
    } core_state_t;

    core_state_t s_r;
    core_state_t s_nxt;

    logic                                    autodetect_q;
    logic                                    ioproc_q;
    logic                                    fifo_in_ready;
    logic                                    fifo_valid;
    logic                                    fifo_pop;
    logic [video_blank_pkg::PIX_W-1:0]       fifo_data;
    logic [video_blank_pkg::LEVEL_W-1:0]     fifo_level;

    // ------------------------------------------------------------------
    // Helpers shared by both channels.
    // ------------------------------------------------------------------

    // Tracks the 3FF 000 000 preamble; TRS_ZERO2 means the next word is XYZ.
    function automatic video_blank_pkg::trs_t trs_next(
        input video_blank_pkg::trs_t                 pre,
        input logic [video_blank_pkg::CHAN_W-1:0]    w
    );
        trs_next = video_blank_pkg::TRS_IDLE;
        if (w == video_blank_pkg::CODE_ONES) begin
            trs_next = video_blank_pkg::TRS_ONES;
        end else if (w == video_blank_pkg::CODE_ZEROS) begin
            unique case (pre)
                video_blank_pkg::TRS_ONES:  trs_next = video_blank_pkg::TRS_ZERO1;
                video_blank_pkg::TRS_ZERO1: trs_next = video_blank_pkg::TRS_ZERO2;
                video_blank_pkg::TRS_IDLE,
                video_blank_pkg::TRS_ZERO2: trs_next = video_blank_pkg::TRS_IDLE;
            endcase
        end
    endfunction

    // Blanks picture and ancillary words; timing codes survive and may get a new field bit.
    function automatic logic [video_blank_pkg::CHAN_W-1:0] chan_word(
        input logic [video_blank_pkg::CHAN_W-1:0]    w,
        input video_blank_pkg::trs_t                 pre,
        input logic [video_blank_pkg::CHAN_W-1:0]    blank_level,
        input logic                                  blanking,
        input logic                                  rewrite,
        input logic                                  field
    );
        logic is_code;
        logic is_xyz;
        logic f;
        logic v;
        logic h;
        is_xyz  = (pre == video_blank_pkg::TRS_ZERO2);
        is_code = is_xyz || (w == video_blank_pkg::CODE_ONES)
                  || ((w == video_blank_pkg::CODE_ZEROS) && (pre != video_blank_pkg::TRS_IDLE));
        chan_word = w;
        if (blanking && !is_code) begin
            chan_word = blank_level;
        end
        if (is_xyz && rewrite) begin
            f = field;
            v = w[video_blank_pkg::V_BIT];
            h = w[video_blank_pkg::H_BIT];
            chan_word[video_blank_pkg::F_BIT]  = f;
            // Protection bits are rebuilt so the receiver does not flag the new word.
            chan_word[video_blank_pkg::P3_BIT] = v ^ h;
            chan_word[video_blank_pkg::P2_BIT] = f ^ h;
            chan_word[video_blank_pkg::P1_BIT] = f ^ v;
            chan_word[video_blank_pkg::P0_BIT] = f ^ v ^ h;
        end
    endfunction

    // ------------------------------------------------------------------
    // Static control pins come from outside the clock domain.
    // ------------------------------------------------------------------
    sync3 u_sync_autodetect (
        .clock (clock),
        .srst  (srst),
        .ce    (ce),
        .d     (timing_code_autodetect),
        .q     (autodetect_q)
    );

    sync3 u_sync_ioproc (
        .clock (clock),
        .srst  (srst),
        .ce    (ce),
        .d     (io_processing_enable),
        .q     (ioproc_q)
    );

    // ------------------------------------------------------------------
    // Buffer between the processing stage and the output register.
    // ------------------------------------------------------------------
    word_fifo #(
        .WIDTH (video_blank_pkg::PIX_W),
        .DEPTH (video_blank_pkg::FIFO_DEPTH),
        .AW    (video_blank_pkg::FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .srst      (srst),
        .ce        (ce),
        .in_valid  (s_r.proc_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (s_r.proc_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data),
        .level     (fifo_level)
    );

    assign fifo_pop = fifo_valid && (!s_r.out_valid || out_ready);

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    always_comb begin
        logic accept;
        logic blanking;
        logic rewrite;
        accept   = 1'b0;
        blanking = 1'b0;
        rewrite  = 1'b0;
        s_nxt    = s_r;

        // Controls travel with the data word of the same cycle.
        accept   = in_valid && s_r.in_ready;
        blanking = !in_ctrl.blank_n || s_r.sw_blank;
        // With autodetect on the field pin has no path to the output at all.
        rewrite  = !autodetect_q && ioproc_q;

        // Processing stage; a word accepted here is pushed one cycle later.
        s_nxt.proc_valid = accept && fifo_in_ready;
        if (accept) begin
            s_nxt.proc_word.luma   = chan_word(in_word.luma, s_r.pre_luma,
                                               video_blank_pkg::BLANK_LUMA,
                                               blanking, rewrite, in_ctrl.field);
            s_nxt.proc_word.chroma = chan_word(in_word.chroma, s_r.pre_chroma,
                                               video_blank_pkg::BLANK_CHROMA,
                                               blanking, rewrite, in_ctrl.field);
            s_nxt.pre_luma     = trs_next(s_r.pre_luma, in_word.luma);
            s_nxt.pre_chroma   = trs_next(s_r.pre_chroma, in_word.chroma);
            s_nxt.blank_active = blanking;
            if (rewrite && (s_r.pre_luma == video_blank_pkg::TRS_ZERO2)) begin
                s_nxt.rewrite_cnt = s_r.rewrite_cnt + 1'b1;
            end
        end

        // Ready is held back early because the processing stage holds one word in flight.
        s_nxt.in_ready = (fifo_level < video_blank_pkg::FILL_LIMIT);

        // Output register.
        if (s_r.out_valid && out_ready) begin
            s_nxt.out_valid = 1'b0;
        end
        if (fifo_pop) begin
            s_nxt.out_valid = 1'b1;
            s_nxt.out_word  = fifo_data;
        end

        // Register writes.
        if (reg_wr && (reg_addr == video_blank_pkg::REG_CTRL)) begin
            s_nxt.sw_blank = reg_wdata[video_blank_pkg::CTRL_SW_BLANK];
        end

        // Register reads; data stands only in the cycle after the strobe.
        s_nxt.rd_data = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                video_blank_pkg::REG_CTRL: begin
                    s_nxt.rd_data[video_blank_pkg::CTRL_SW_BLANK] = s_r.sw_blank;
                end
                video_blank_pkg::REG_STATUS: begin
                    s_nxt.rd_data[video_blank_pkg::ST_BLANKING]   = s_r.blank_active;
                    s_nxt.rd_data[video_blank_pkg::ST_REWRITE]    = rewrite;
                    s_nxt.rd_data[video_blank_pkg::ST_AUTODETECT] = autodetect_q;
                    s_nxt.rd_data[video_blank_pkg::ST_IOPROC]     = ioproc_q;
                    s_nxt.rd_data[video_blank_pkg::ST_LEVEL_LSB +: video_blank_pkg::LEVEL_W]
                        = fifo_level;
                end
                video_blank_pkg::REG_COUNT: begin
                    s_nxt.rd_data[video_blank_pkg::COUNT_W-1:0] = s_r.rewrite_cnt;
                end
                default: begin
                    s_nxt.rd_data = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register; the clock enable freezes everything.
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            s_r          <= '0;
            s_r.sw_blank <= video_blank_pkg::CTRL_SW_BLANK_RESET;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // All outputs come straight from the state register.
    assign in_ready  = s_r.in_ready;
    assign out_valid = s_r.out_valid;
    assign out_word  = s_r.out_word;
    assign reg_rdata = s_r.rd_data;

endmodule

// File: dv/video_blank_field_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port checker for the blanking and field flag block.
// ----------------------------------------------------------------------
module video_blank_field_asserts (
    input wire logic                                clock,
    input wire logic                                srst,
    input wire logic                                ce,
    input wire logic                                in_valid,
    input wire logic                                in_ready,
    input wire video_blank_pkg::pix_word_t          in_word,
    input wire video_blank_pkg::pix_ctrl_t          in_ctrl,
    input wire logic                                timing_code_autodetect,
    input wire logic                                io_processing_enable,
    input wire logic                                out_valid,
    input wire logic                                out_ready,
    input wire video_blank_pkg::pix_word_t          out_word,
    input wire logic [video_blank_pkg::ADDR_W-1:0]  reg_addr,
    input wire logic [31:0]                         reg_wdata,
    input wire logic                                reg_wr,
    input wire logic                                reg_rd,
    input wire logic [31:0]                         reg_rdata
);
    logic       take;
    logic       plain;
    logic       xyz;
    logic [5:0] inflight_r;
    logic [2:0] pin_age_r;
    logic [1:0] pins_r;
    logic       sw_r;
    logic [9:0] lum1_r;
    logic [9:0] lum2_r;
    logic [9:0] lum3_r;

    // Latency holds only on an empty path, so words in flight are counted.
    assign take  = ce && in_valid && in_ready;
    assign xyz   = lum3_r == 10'h3ff && lum2_r == 10'h000 && lum1_r == 10'h000;
    assign plain = !xyz && !(in_word.luma inside {10'h3ff, 10'h000})
                   && !(in_word.chroma inside {10'h3ff, 10'h000});

    // Helper state; pin age outlasts the synchroniser delay.
    always_ff @(posedge clock) begin
        if (srst) begin
            inflight_r <= 6'h00;
            pin_age_r  <= 3'h0;
            pins_r     <= 2'h0;
            sw_r       <= 1'b0;
            lum1_r     <= 10'h000;
            lum2_r     <= 10'h000;
            lum3_r     <= 10'h000;
        end else begin
            inflight_r <= inflight_r + 6'(take) - 6'(out_valid && out_ready);
            pins_r     <= {timing_code_autodetect, io_processing_enable};
            if (pins_r != {timing_code_autodetect, io_processing_enable}) begin
                pin_age_r <= 3'h0;
            end else if (pin_age_r != 3'h7) begin
                pin_age_r <= pin_age_r + 3'h1;
            end
            if (reg_wr && reg_addr == video_blank_pkg::REG_CTRL) begin
                sw_r <= reg_wdata[video_blank_pkg::CTRL_SW_BLANK];
            end
            if (take) begin
                lum1_r <= in_word.luma;
                lum2_r <= lum1_r;
                lum3_r <= lum2_r;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    reset_quiet_a: assert property (disable iff (1'b0) srst |=> !in_ready && !out_valid
        && out_word == 20'h0_0000 && reg_rdata == 32'h0000_0000)
        else $error("outputs not quiet after reset");
    blank_words_a: assert property (take && inflight_r == 6'h00 && plain
        && (!in_ctrl.blank_n || sw_r) ##0 out_ready [*4] |-> out_valid
        && out_word.luma == video_blank_pkg::BLANK_LUMA
        && out_word.chroma == video_blank_pkg::BLANK_CHROMA)
        else $error("word not replaced by blanking levels");
    pass_words_a: assert property (take && inflight_r == 6'h00 && plain
        && in_ctrl.blank_n && !sw_r ##0 out_ready [*4] |-> out_valid
        && out_word == $past(in_word, 3))
        else $error("word altered while blanking off");
    field_bit_a: assert property (take && inflight_r == 6'h00 && xyz && pin_age_r == 3'h7
        && !timing_code_autodetect && io_processing_enable ##0 out_ready [*4]
        |-> out_valid && out_word.luma[video_blank_pkg::F_BIT] == $past(in_ctrl.field, 3))
        else $error("field bit does not follow field input");
    field_ignore_a: assert property (take && inflight_r == 6'h00 && xyz && pin_age_r == 3'h7
        && (timing_code_autodetect || !io_processing_enable) ##0 out_ready [*4]
        |-> out_valid && out_word.luma == $past(in_word.luma, 3))
        else $error("timing word changed with rewrite off");
    out_hold_a: assert property (ce && out_valid && !out_ready |=> out_valid
        && $stable(out_word))
        else $error("output word dropped before acceptance");
    rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    empty_idle_a: assert property (inflight_r == 6'h00 |-> !out_valid)
        else $error("output valid with no word taken");

    cover_blank_c: cover property (take && !in_ctrl.blank_n && plain);
    cover_rewrite_c: cover property (take && xyz && in_ctrl.field);
    cover_full_c: cover property (in_valid && !in_ready && inflight_r > 6'h08);
endmodule

bind video_blank_field video_blank_field_asserts chk (.*);

// File: dv/video_source_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Parallel video source: holds each word until the block takes it.
// ----------------------------------------------------------------------
module video_source_model (
    input  wire logic                  clock,
    input  wire logic                  in_ready,
    output video_blank_pkg::pix_word_t in_word,
    output video_blank_pkg::pix_ctrl_t in_ctrl,
    output logic                       in_valid,
    output logic                       stuck
);
    initial begin
        in_valid = 1'b0;
        in_word  = 20'h0_0000;
        in_ctrl  = 2'h3;
        stuck    = 1'b0;
    end

    // Word and its controls change together and stand until taken.
    task automatic send(input video_blank_pkg::pix_word_t w, input video_blank_pkg::pix_ctrl_t c);
        int n;
        in_valid <= 1'b1;
        in_word  <= w;
        in_ctrl  <= c;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (!in_ready && n < 200);
        if (!in_ready) stuck <= 1'b1;
    endtask

    // Released lines flip so a stale word can never pass for a fresh one.
    task automatic idle();
        in_valid <= 1'b0;
        in_word  <= ~in_word;
        in_ctrl  <= ~in_ctrl;
    endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Testbench for the blanking and field flag block.
// ----------------------------------------------------------------------
module tb;
    typedef struct packed {
        logic [9:0] l;
        logic [9:0] c;
        logic       b;
        logic       f;
        logic [9:0] el;
        logic [9:0] ec;
    } row_t;

    logic clock, srst, ce, in_valid, in_ready, autodetect, ioproc, out_valid, out_ready;
    logic reg_wr, reg_rd;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    video_blank_pkg::pix_word_t in_word, out_word;
    video_blank_pkg::pix_ctrl_t in_ctrl;
    logic [19:0] got_q[$], exp_q[$];
    int          err_total, comparisons;
    // Luma, chroma, blank_n, field, expected luma, expected chroma.
    row_t rows [12] = '{
        '{10'h100, 10'h180, 1'b1, 1'b0, 10'h100, 10'h180},
        '{10'h100, 10'h180, 1'b0, 1'b0, 10'h040, 10'h200},
        '{10'h3ff, 10'h3ff, 1'b0, 1'b1, 10'h3ff, 10'h3ff},
        '{10'h000, 10'h000, 1'b0, 1'b1, 10'h000, 10'h000},
        '{10'h000, 10'h000, 1'b0, 1'b1, 10'h000, 10'h000},
        '{10'h200, 10'h200, 1'b0, 1'b1, 10'h31c, 10'h31c},
        '{10'h3a5, 10'h0f0, 1'b1, 1'b0, 10'h3a5, 10'h0f0},
        '{10'h3ff, 10'h3ff, 1'b1, 1'b0, 10'h3ff, 10'h3ff},
        '{10'h000, 10'h000, 1'b1, 1'b0, 10'h000, 10'h000},
        '{10'h000, 10'h000, 1'b1, 1'b0, 10'h000, 10'h000},
        '{10'h3b4, 10'h3b4, 1'b1, 1'b0, 10'h2ac, 10'h2ac},
        '{10'h000, 10'h3ff, 1'b0, 1'b0, 10'h040, 10'h3ff}
    };

    video_blank_field uut (.*, .timing_code_autodetect(autodetect),
        .io_processing_enable(ioproc));
    video_source_model src (
        .clock(clock), .in_ready(in_ready), .in_word(in_word), .in_ctrl(in_ctrl),
        .in_valid(in_valid), .stuck()
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Sink side collects every accepted word in order.
    always @(posedge clock) begin
        if (out_valid && out_ready) got_q.push_back(out_word);
    end

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", n, exp, seen);
            err_total++;
        end
    endtask

    task automatic conclude();
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Waits are bounded; a stuck source or a missing word ends the run.
    task automatic drain();
        int n;
        n = 0;
        while (got_q.size() < exp_q.size() && n < 300) begin
            @(posedge clock);
            n++;
        end
        if (src.stuck || got_q.size() != exp_q.size()) begin
            err_total++;
            conclude();
        end
        while (exp_q.size() > 0) check("out_word", got_q.pop_front(), exp_q.pop_front());
    endtask

    task automatic put(input logic [19:0] w, input logic [1:0] c, input logic [19:0] e);
        src.send(w, c);
        src.idle();
        exp_q.push_back(e);
        repeat (5) @(posedge clock);
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [31:0] e, input string n);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        check(n, reg_rdata, e);
    endtask

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        autodetect = 1'b0;
        ioproc = 1'b1;
        out_ready = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        repeat (10) @(posedge clock);
        check("reset_out", {in_ready, out_valid, out_word}, 32'h0000_0000);
        srst <= 1'b0;
        repeat (8) @(posedge clock);
        foreach (rows[i]) put({rows[i].l, rows[i].c}, {rows[i].b, rows[i].f},
            {rows[i].el, rows[i].ec});
        drain();
        // Autodetect on, then processing off: the timing word must pass untouched.
        for (int k = 0; k < 2; k++) begin
            autodetect <= (k == 0);
            ioproc     <= (k == 1) ? 1'b0 : 1'b1;
            repeat (10) @(posedge clock);
            put(20'hf_ffff, 2'h1, 20'hf_ffff);
            put(20'h0_0000, 2'h1, 20'h0_0000);
            put(20'h0_0000, 2'h1, 20'h0_0000);
            put(20'h8_0200, 2'h1, 20'h8_0200);
        end
        autodetect <= 1'b0;
        ioproc     <= 1'b1;
        repeat (10) @(posedge clock);
        drain();
        reg_read(video_blank_pkg::REG_COUNT, 32'h0000_0002, "count");
        reg_write(video_blank_pkg::REG_CTRL, 32'h0000_0001);
        reg_write(4'hc, 32'h0000_0000);
        reg_read(video_blank_pkg::REG_CTRL, 32'h0000_0001, "ctrl");
        put(20'h5_56aa, 2'h2, 20'h1_0200);
        drain();
        reg_read(video_blank_pkg::REG_STATUS, 32'h0000_000b, "status");
        reg_read(4'hc, 32'h0000_0000, "unmapped");
        reg_write(video_blank_pkg::REG_CTRL, 32'h0000_0000);
        // Sink stalls for 40 cycles while twenty words are offered; none may be lost.
        out_ready <= 1'b0;
        for (int i = 0; i < 20; i++) exp_q.push_back({10'h010 + 10'(i), 10'h020 + 10'(i)});
        fork
            begin
                for (int i = 0; i < 20; i++) src.send({10'h010 + 10'(i), 10'h020 + 10'(i)}, 2'h2);
                src.idle();
            end
            begin
                repeat (40) @(posedge clock);
                check("in_ready", {31'h0000_0000, in_ready}, 32'h0000_0000);
                out_ready <= 1'b1;
            end
        join
        drain();
        conclude();
    end
endmodule
